// *** rtl/bsr_ahb_if.sv ***
`timescale 1ns/1ps
module bsr_ahb_if (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // register side
  output logic [8:0] o_idx,
  output logic o_wr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);

  typedef enum logic [1:0] {AHB_IDLE, AHB_WRITE, AHB_READ_WAIT, AHB_READ_DONE} bsr_ahb_e;
  bsr_ahb_e state_q;
  logic take;

  assign take = i_hsel && i_hready && i_htrans[1];
  // reads take one wait state so that read data come from a flop
  assign o_hreadyout = (state_q != AHB_READ_WAIT);
  assign o_hresp = 1'b0;
  assign o_wr = (state_q == AHB_WRITE);
  assign o_wdata = i_hwdata[7:0];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= AHB_IDLE;
    end else begin
      case (state_q)
        AHB_READ_WAIT: state_q <= AHB_READ_DONE;
        default: begin
          if (take) begin
            state_q <= i_hwrite ? AHB_WRITE : AHB_READ_WAIT;
          end else begin
            state_q <= AHB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_idx <= 9'h000;
    end else if (take && o_hreadyout) begin
      o_idx <= i_haddr[10:2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (state_q == AHB_READ_WAIT) begin
      o_hrdata <= {24'h00_0000, i_rdata};
    end
  end

endmodule

// *** rtl/bsr_pkg.sv ***
package bsr_pkg;

  // register indices (byte address on the bus is four times the index)
  localparam logic [7:0] OFF_INDIRECT_ACCESS_PORT = 8'h80;
  localparam logic [7:0] OFF_TIMER_AND_PULLUP_OPTIONS = 8'h81;
  localparam logic [7:0] OFF_PROGRAM_COUNTER_LOW = 8'h82;
  localparam logic [7:0] OFF_CORE_FLAGS = 8'h83;
  localparam logic [7:0] OFF_INDIRECT_POINTER = 8'h84;
  localparam logic [7:0] OFF_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] OFF_PORT_B_DIRECTION = 8'h86;
  localparam logic [7:0] OFF_PROGRAM_COUNTER_HIGH_LATCH = 8'h8a;
  localparam logic [7:0] OFF_INTERRUPT_CONTROL = 8'h8b;
  localparam logic [7:0] OFF_PERIPHERAL_IRQ_ENABLE_ONE = 8'h8c;
  localparam logic [7:0] OFF_PERIPHERAL_IRQ_ENABLE_TWO = 8'h8d;
  localparam logic [7:0] OFF_RESET_CAUSE_FLAGS = 8'h8e;
  localparam logic [7:0] OFF_OSCILLATOR_CONTROL = 8'h8f;
  localparam logic [7:0] OFF_OSCILLATOR_TUNING = 8'h90;
  localparam logic [7:0] OFF_TIMER2_PERIOD = 8'h92;
  localparam logic [7:0] OFF_SERIAL_SLAVE_ADDRESS = 8'h93;
  localparam logic [7:0] OFF_SERIAL_PORT_STATUS = 8'h94;
  localparam logic [7:0] OFF_CONVERSION_RESULT_LOW = 8'h9e;
  localparam logic [7:0] OFF_CONVERSION_CONFIG_ONE = 8'h9f;

  // bank number carried in index bits 8:7
  localparam logic [1:0] BANK_ONE = 2'h1;

  // core flags: irp rp1 rp0 timeout powerdown zero digit_carry carry
  localparam logic [7:0] RST_CORE_FLAGS = 8'h18;
  localparam logic [7:0] RSTM_CORE_FLAGS = 8'hf8;
  localparam logic [7:0] WM_CORE_FLAGS = 8'he7;
  localparam int CF_RP_LO = 5;
  localparam int CF_SLEEP_LO = 3;

  // interrupt control: bits 2:0 are event flags, bit 0 not reset
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RSTM_INTERRUPT_CONTROL = 8'hfe;

  // reset cause flags: bit 1 power-on, bit 0 brown-out, low means it happened
  localparam logic [7:0] WM_RESET_CAUSE_FLAGS = 8'h03;
  localparam int RC_POR = 1;
  localparam int RC_BROWN_OUT = 0;

  // hardware-driven bits merged on read, and output field offsets
  localparam int OSC_STABLE_BIT = 2;
  localparam logic [7:0] SERIAL_STATUS_MASK = 8'h3f;
  localparam int OSC_FREQ_LO = 4;
  localparam int SERIAL_CFG_LO = 6;

  // plain storage registers, one entry each
  localparam int SIMPLE_N = 13;
  localparam int SI_TIMER_OPT = 0;
  localparam int SI_POINTER = 1;
  localparam int SI_PORT_A = 2;
  localparam int SI_PORT_B = 3;
  localparam int SI_PC_LATCH = 4;
  localparam int SI_IRQ_EN_ONE = 5;
  localparam int SI_IRQ_EN_TWO = 6;
  localparam int SI_OSC_CTRL = 7;
  localparam int SI_OSC_TUNE = 8;
  localparam int SI_T2_PERIOD = 9;
  localparam int SI_SER_ADDR = 10;
  localparam int SI_SER_STAT = 11;
  localparam int SI_CONV_CFG = 12;

  localparam logic [7:0] SMP_OFF [0:SIMPLE_N-1] = '{
    OFF_TIMER_AND_PULLUP_OPTIONS, OFF_INDIRECT_POINTER, OFF_PORT_A_DIRECTION,
    OFF_PORT_B_DIRECTION, OFF_PROGRAM_COUNTER_HIGH_LATCH, OFF_PERIPHERAL_IRQ_ENABLE_ONE,
    OFF_PERIPHERAL_IRQ_ENABLE_TWO, OFF_OSCILLATOR_CONTROL, OFF_OSCILLATOR_TUNING,
    OFF_TIMER2_PERIOD, OFF_SERIAL_SLAVE_ADDRESS, OFF_SERIAL_PORT_STATUS,
    OFF_CONVERSION_CONFIG_ONE};
  localparam logic [7:0] SMP_RST [0:SIMPLE_N-1] = '{
    8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  // bits that take the reset value; the pointer is left unknown
  localparam logic [7:0] SMP_RSTM [0:SIMPLE_N-1] = '{
    8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  // implemented, software-writable bits
  localparam logic [7:0] SMP_WM [0:SIMPLE_N-1] = '{
    8'hff, 8'hff, 8'hdf, 8'hff, 8'h1f, 8'h4f, 8'h10,
    8'h70, 8'h3f, 8'hff, 8'hff, 8'hc0, 8'hcf};
  // bits that always read as one
  localparam logic [7:0] SMP_ONE [0:SIMPLE_N-1] = '{
    8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic SMP_MIRROR [0:SIMPLE_N-1] = '{
    1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
    1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// *** rtl/bsr_reg8.sv ***
`timescale 1ns/1ps
module bsr_reg8 #(
  parameter logic [7:0] P_RST = 8'h00,
  parameter logic [7:0] P_RSTM = 8'hff,
  parameter logic [7:0] P_WM = 8'hff
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // write port
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  // stored value
  output logic [7:0] o_q
);

  // bits outside the reset mask keep whatever they held
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_q <= (o_q & ~P_RSTM) | (P_RST & P_RSTM);
    end else if (i_we) begin
      o_q <= (o_q & ~P_WM) | (i_wdata & P_WM);
    end
  end

endmodule

// *** rtl/bsr_top.sv ***
// Notes on behaviour
// RULE_01 - empty addresses and bits read zero
// RULE_02 - mirrored core registers decode in every bank
// RULE_03 - no address reaches program counter upper byte
// RULE_04 - five-bit latch loads counter bits twelve to eight on a low-byte write, only bits twelve and eleven on a jump
// RULE_05 - port A bit five direction reads one
// RULE_06 - reset cause flags follow the reset kind
// RULE_07 - unknown reset bits keep their contents
// RULE_08 - writes to empty places change nothing
`timescale 1ns/1ps
module bsr_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // program counter control from the core
  input wire logic i_pc_step,
  input wire logic i_pc_jump,
  input wire logic [10:0] i_jump_target,
  output logic [12:0] o_program_counter,
  // core flag updates
  input wire logic i_alu_flags_we,
  input wire logic [2:0] i_alu_flags,
  input wire logic i_sleep_flags_we,
  input wire logic [1:0] i_sleep_flags,
  output logic [7:0] o_core_flags,
  // interrupt event flags
  input wire logic [2:0] i_irq_flag_set,
  output logic [7:0] o_interrupt_control,
  // reset cause
  input wire logic i_reset_was_por,
  input wire logic i_reset_was_brown_out,
  output logic [1:0] o_reset_cause_flags,
  // indirect data memory access
  output logic [8:0] o_indirect_addr,
  output logic o_indirect_wr,
  output logic [7:0] o_indirect_wdata,
  input wire logic [7:0] i_indirect_rdata,
  // peripheral status inputs
  input wire logic i_osc_stable,
  input wire logic [5:0] i_serial_status,
  input wire logic [7:0] i_conversion_result_low,
  // configuration outputs
  output logic [7:0] o_timer_and_pullup_options,
  output logic [7:0] o_port_a_direction,
  output logic [7:0] o_port_b_direction,
  output logic [7:0] o_peripheral_irq_enable_one,
  output logic [7:0] o_peripheral_irq_enable_two,
  output logic [2:0] o_oscillator_freq_select,
  output logic [5:0] o_oscillator_tuning,
  output logic [7:0] o_timer2_period,
  output logic [7:0] o_serial_slave_address,
  output logic [1:0] o_serial_port_config,
  output logic [7:0] o_conversion_config_one
);

  logic [8:0] idx;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] smp_q [0:bsr_pkg::SIMPLE_N-1];
  logic [bsr_pkg::SIMPLE_N-1:0] smp_hit;
  logic hit_indirect;
  logic hit_pc_low;
  logic hit_flags;
  logic hit_irq_ctrl;
  logic hit_cause;
  logic hit_result;
  logic [12:0] pc_q;
  logic [7:0] flags_q;
  logic [7:0] irq_ctrl_q;
  logic [1:0] cause_q;
  logic [7:0] flags_wr;
  logic [7:0] irq_ctrl_wr;
  logic [4:0] pc_latch;
  logic unused_size;
  logic wr_indirect;
  logic wr_pc_low;
  logic wr_flags;
  logic wr_irq_ctrl;
  logic wr_cause;
  logic ind_wr_q;
  logic [7:0] ind_wdata_q;

  assign unused_size = ^i_hsize;

  bsr_ahb_if u_ahb (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hready(i_hready),
    .i_hwdata(i_hwdata),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_idx(idx),
    .o_wr(wr),
    .o_wdata(wdata),
    .i_rdata(rdata)
  );

  // index hit: mirrored entries ignore the bank bits
  function automatic logic idx_hit(input logic [8:0] a, input logic [7:0] off,
                                   input logic mir);
    logic same_low;
    same_low = (a[6:0] == off[6:0]);
    if (mir) begin
      idx_hit = same_low;
    end else begin
      idx_hit = same_low && (a[8:7] == bsr_pkg::BANK_ONE);
    end
  endfunction

  // RULE_02 mirrored decode for the first four; cause and result decode in bank one only
  assign hit_indirect = idx_hit(idx, bsr_pkg::OFF_INDIRECT_ACCESS_PORT, 1'b1);
  assign hit_pc_low = idx_hit(idx, bsr_pkg::OFF_PROGRAM_COUNTER_LOW, 1'b1);
  assign hit_flags = idx_hit(idx, bsr_pkg::OFF_CORE_FLAGS, 1'b1);
  assign hit_irq_ctrl = idx_hit(idx, bsr_pkg::OFF_INTERRUPT_CONTROL, 1'b1);
  assign hit_cause = idx_hit(idx, bsr_pkg::OFF_RESET_CAUSE_FLAGS, 1'b0);
  assign hit_result = idx_hit(idx, bsr_pkg::OFF_CONVERSION_RESULT_LOW, 1'b0);

  // RULE_08 unmatched writes enable nothing
  assign wr_indirect = wr && hit_indirect;
  assign wr_pc_low = wr && hit_pc_low;
  assign wr_flags = wr && hit_flags;
  assign wr_irq_ctrl = wr && hit_irq_ctrl;
  assign wr_cause = wr && hit_cause;

  // storage registers, one per table entry
  generate
    for (genvar gi = 0; gi < bsr_pkg::SIMPLE_N; gi++) begin : g_smp
      assign smp_hit[gi] = idx_hit(idx, bsr_pkg::SMP_OFF[gi], bsr_pkg::SMP_MIRROR[gi]);
      // RULE_07 partial reset
      bsr_reg8 #(
        .P_RST(bsr_pkg::SMP_RST[gi]),
        .P_RSTM(bsr_pkg::SMP_RSTM[gi]),
        .P_WM(bsr_pkg::SMP_WM[gi])
      ) u_reg (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(wr && smp_hit[gi]),
        .i_wdata(wdata),
        .o_q(smp_q[gi])
      );
    end
  endgenerate

  // RULE_04 latch holds counter bits 12:8
  assign pc_latch = smp_q[bsr_pkg::SI_PC_LATCH][4:0];

  // RULE_04 latch loaded into upper counter
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pc_q <= 13'h0000;
    end else if (wr_pc_low) begin
      pc_q <= {pc_latch, wdata};
    end else if (i_pc_jump) begin
      pc_q <= {pc_latch[4:3], i_jump_target};
    end else if (i_pc_step) begin
      pc_q <= pc_q + 13'h0001;
    end
  end

  // core flags: core updates win over a software write
  always_comb begin
    flags_wr = (flags_q & ~bsr_pkg::WM_CORE_FLAGS) | (wdata & bsr_pkg::WM_CORE_FLAGS);
    if (i_alu_flags_we) begin
      flags_wr[2:0] = i_alu_flags;
    end
    if (i_sleep_flags_we) begin
      flags_wr[bsr_pkg::CF_SLEEP_LO +: 2] = i_sleep_flags;
    end
  end

  // RULE_07 carry flags not reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flags_q <= (flags_q & ~bsr_pkg::RSTM_CORE_FLAGS) |
                 (bsr_pkg::RST_CORE_FLAGS & bsr_pkg::RSTM_CORE_FLAGS);
    end else if (wr_flags) begin
      flags_q <= flags_wr;
    end else begin
      if (i_alu_flags_we) begin
        flags_q[2:0] <= i_alu_flags;
      end
      if (i_sleep_flags_we) begin
        flags_q[bsr_pkg::CF_SLEEP_LO +: 2] <= i_sleep_flags;
      end
    end
  end

  // event flags: a set in the clearing cycle survives
  assign irq_ctrl_wr = wdata | {5'h00, i_irq_flag_set};

  // RULE_07 bit 0 keeps contents
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_ctrl_q <= (irq_ctrl_q & ~bsr_pkg::RSTM_INTERRUPT_CONTROL) |
                    (bsr_pkg::RST_INTERRUPT_CONTROL & bsr_pkg::RSTM_INTERRUPT_CONTROL);
    end else if (wr_irq_ctrl) begin
      irq_ctrl_q <= irq_ctrl_wr;
    end else begin
      irq_ctrl_q[2:0] <= irq_ctrl_q[2:0] | i_irq_flag_set;
    end
  end

  // RULE_06 flags reflect reset kind
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cause_q[bsr_pkg::RC_POR] <= ~i_reset_was_por;
      cause_q[bsr_pkg::RC_BROWN_OUT] <= ~i_reset_was_brown_out;
    end else if (wr_cause) begin
      cause_q <= wdata[1:0] & bsr_pkg::WM_RESET_CAUSE_FLAGS[1:0];
    end
  end

  // RULE_01 read mux, zero default
  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < bsr_pkg::SIMPLE_N; i++) begin
      // RULE_05 bit five forced high
      if (smp_hit[i]) begin
        rdata = rdata | (smp_q[i] & bsr_pkg::SMP_WM[i]) | bsr_pkg::SMP_ONE[i];
      end
    end
    if (smp_hit[bsr_pkg::SI_OSC_CTRL]) begin
      rdata[bsr_pkg::OSC_STABLE_BIT] = i_osc_stable;
    end
    if (smp_hit[bsr_pkg::SI_SER_STAT]) begin
      rdata = rdata | ({2'h0, i_serial_status} & bsr_pkg::SERIAL_STATUS_MASK);
    end
    if (hit_indirect) begin
      rdata = i_indirect_rdata;
    end
    // RULE_03 only the low byte is visible
    if (hit_pc_low) begin
      rdata = pc_q[7:0];
    end
    if (hit_flags) begin
      rdata = flags_q;
    end
    if (hit_irq_ctrl) begin
      rdata = irq_ctrl_q;
    end
    if (hit_cause) begin
      rdata = {6'h00, cause_q};
    end
    if (hit_result) begin
      rdata = i_conversion_result_low;
    end
  end

  // indirect writes leave through flops so the write data output is registered
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ind_wr_q <= 1'b0;
      ind_wdata_q <= 8'h00;
    end else begin
      ind_wr_q <= wr_indirect;
      if (wr_indirect) begin
        ind_wdata_q <= wdata;
      end
    end
  end

  assign o_indirect_wr = ind_wr_q;
  assign o_indirect_wdata = ind_wdata_q;
  // address follows the pointer live so indirect reads see it at once
  assign o_indirect_addr = {flags_q[7], smp_q[bsr_pkg::SI_POINTER]};

  // outputs
  assign o_program_counter = pc_q;
  assign o_core_flags = flags_q;
  assign o_interrupt_control = irq_ctrl_q;
  assign o_reset_cause_flags = cause_q;
  assign o_timer_and_pullup_options = smp_q[bsr_pkg::SI_TIMER_OPT];
  assign o_port_a_direction = smp_q[bsr_pkg::SI_PORT_A] | bsr_pkg::SMP_ONE[bsr_pkg::SI_PORT_A];
  assign o_port_b_direction = smp_q[bsr_pkg::SI_PORT_B];
  assign o_peripheral_irq_enable_one = smp_q[bsr_pkg::SI_IRQ_EN_ONE] &
                                       bsr_pkg::SMP_WM[bsr_pkg::SI_IRQ_EN_ONE];
  assign o_peripheral_irq_enable_two = smp_q[bsr_pkg::SI_IRQ_EN_TWO] &
                                       bsr_pkg::SMP_WM[bsr_pkg::SI_IRQ_EN_TWO];
  assign o_oscillator_freq_select = smp_q[bsr_pkg::SI_OSC_CTRL][bsr_pkg::OSC_FREQ_LO +: 3];
  assign o_oscillator_tuning = smp_q[bsr_pkg::SI_OSC_TUNE][5:0];
  assign o_timer2_period = smp_q[bsr_pkg::SI_T2_PERIOD];
  assign o_serial_slave_address = smp_q[bsr_pkg::SI_SER_ADDR];
  assign o_serial_port_config = smp_q[bsr_pkg::SI_SER_STAT][bsr_pkg::SERIAL_CFG_LO +: 2];
  assign o_conversion_config_one = smp_q[bsr_pkg::SI_CONV_CFG] &
                                   bsr_pkg::SMP_WM[bsr_pkg::SI_CONV_CFG];

endmodule

// *** test/bsr_chk.sv ***
`timescale 1ns/1ps
module bsr_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // bus
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  // core side
  input wire logic i_pc_step,
  input wire logic i_pc_jump,
  input wire logic [10:0] i_jump_target,
  input wire logic [12:0] o_program_counter,
  input wire logic i_sleep_flags_we,
  input wire logic [1:0] i_sleep_flags,
  input wire logic [7:0] o_core_flags,
  input wire logic [2:0] i_irq_flag_set,
  input wire logic [7:0] o_interrupt_control,
  input wire logic i_reset_was_por,
  input wire logic i_reset_was_brown_out,
  input wire logic [1:0] o_reset_cause_flags,
  // configuration
  input wire logic [7:0] o_port_a_direction,
  input wire logic [7:0] o_peripheral_irq_enable_one,
  input wire logic [7:0] o_peripheral_irq_enable_two
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_req;
    i_hsel && i_hready && i_htrans[1];
  endsequence
  sequence s_rd_answer;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  a_read_one_wait: assert property (s_req and !i_hwrite |=> s_rd_answer)
    else $error("read did not take exactly one wait state");
  a_write_no_wait: assert property (s_req and i_hwrite |=> o_hreadyout)
    else $error("write data phase stalled");
  a_rdata_upper_zero: assert property (o_hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_irq_en_masks: assert property ((o_peripheral_irq_enable_one & 8'hb0) == 8'h00 &&
    (o_peripheral_irq_enable_two & 8'hef) == 8'h00)
    else $error("unimplemented enable bit is set");
  a_port_a_bit5: assert property (o_port_a_direction[5])
    else $error("port A bit 5 direction not one");
  a_cause_on_reset: assert property ($fell(i_sys_rst) |->
    o_reset_cause_flags == ~{$past(i_reset_was_por), $past(i_reset_was_brown_out)})
    else $error("reset cause flags wrong after reset");
  a_jump_low_bits: assert property (i_pc_jump |=>
    o_program_counter[10:0] == $past(i_jump_target))
    else $error("jump target not loaded");
  a_step_counts: assert property (i_pc_step && !i_pc_jump |=>
    o_program_counter == $past(o_program_counter) + 13'h1)
    else $error("counter step wrong");
  a_sleep_flags_load: assert property (i_sleep_flags_we |=>
    o_core_flags[4:3] == $past(i_sleep_flags))
    else $error("sleep flags not loaded");
  a_irq_flag_set: assert property (|i_irq_flag_set |=>
    (o_interrupt_control[2:0] & $past(i_irq_flag_set)) == $past(i_irq_flag_set))
    else $error("interrupt event flag not set");
endmodule
bind bsr_top bsr_chk u_chk (.i_clk, .i_sys_rst, .i_hsel, .i_htrans, .i_hwrite, .i_hready,
  .o_hrdata, .o_hreadyout, .i_pc_step, .i_pc_jump, .i_jump_target, .o_program_counter,
  .i_sleep_flags_we, .i_sleep_flags, .o_core_flags, .i_irq_flag_set, .o_interrupt_control,
  .i_reset_was_por, .i_reset_was_brown_out, .o_reset_cause_flags, .o_port_a_direction,
  .o_peripheral_irq_enable_one, .o_peripheral_irq_enable_two);

// *** test/bsr_mem_model.sv ***
`timescale 1ns/1ps
module bsr_mem_model (
  // clock
  input wire logic i_clk,
  // indirect access from the bank
  input wire logic [8:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  // unwritten cells stay unknown, like uninitialised data memory
  logic [7:0] mem [0:511];
  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
  end
  assign o_rdata = mem[i_addr];
endmodule

// *** test/test_bank1_special_register_decode.sv ***
`timescale 1ns/1ps
module test_bank1_special_register_decode;
  logic i_clk = 0, i_sys_rst = 1, i_hsel = 0, i_hwrite = 0;
  logic [31:0] i_haddr = 0, i_hwdata = 0;
  logic [1:0] i_htrans = 0, i_sleep_flags = 0;
  logic [2:0] i_hsize = 3'h2, i_alu_flags = 0, i_irq_flag_set = 0;
  logic i_pc_step = 0, i_pc_jump = 0, i_alu_flags_we = 0, i_sleep_flags_we = 0;
  logic [10:0] i_jump_target = 0;
  logic i_reset_was_por = 1, i_reset_was_brown_out = 0, i_osc_stable = 1;
  logic [5:0] i_serial_status = 6'h2a;
  logic [7:0] i_conversion_result_low = 8'h5c;
  logic [31:0] o_hrdata;
  logic o_hreadyout, o_hresp, o_indirect_wr;
  logic [12:0] o_program_counter;
  logic [7:0] o_core_flags, o_interrupt_control, o_indirect_wdata, i_indirect_rdata;
  logic [1:0] o_reset_cause_flags, o_serial_port_config;
  logic [8:0] o_indirect_addr;
  logic [7:0] o_timer_and_pullup_options, o_port_a_direction, o_port_b_direction;
  logic [7:0] o_peripheral_irq_enable_one, o_peripheral_irq_enable_two;
  logic [7:0] o_timer2_period, o_serial_slave_address, o_conversion_config_one;
  logic [2:0] o_oscillator_freq_select;
  logic [5:0] o_oscillator_tuning;
  wire i_hready = o_hreadyout;
  int error_cnt = 0;
  int check_count = 0;
  always #12.5 i_clk = ~i_clk;
  bsr_top i_dut (.i_clk, .i_sys_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hready, .i_hwdata, .o_hrdata, .o_hreadyout, .o_hresp, .i_pc_step, .i_pc_jump,
    .i_jump_target, .o_program_counter, .i_alu_flags_we, .i_alu_flags, .i_sleep_flags_we,
    .i_sleep_flags, .o_core_flags, .i_irq_flag_set, .o_interrupt_control, .i_reset_was_por,
    .i_reset_was_brown_out, .o_reset_cause_flags, .o_indirect_addr, .o_indirect_wr,
    .o_indirect_wdata, .i_indirect_rdata, .i_osc_stable, .i_serial_status,
    .i_conversion_result_low, .o_timer_and_pullup_options, .o_port_a_direction,
    .o_port_b_direction, .o_peripheral_irq_enable_one, .o_peripheral_irq_enable_two,
    .o_oscillator_freq_select, .o_oscillator_tuning, .o_timer2_period,
    .o_serial_slave_address, .o_serial_port_config, .o_conversion_config_one);
  bsr_mem_model i_mem (.i_clk, .i_addr(o_indirect_addr), .i_wr(o_indirect_wr),
    .i_wdata(o_indirect_wdata), .o_rdata(i_indirect_rdata));
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 20) begin
        error_cnt++;
        test_done();
      end
    end while (o_hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_haddr <= {21'h0, a, 2'b00};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    wt();
    i_htrans <= 2'h0;
    i_hsel <= 1'b0;
    i_hwdata <= {24'hffff_ff, d};
    wt();
    q = o_hrdata[7:0];
    chk({15'h0000, o_hresp}, 16'h0000);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic rst(input logic p, input logic b);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    i_reset_was_por <= p;
    i_reset_was_brown_out <= b;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
  endtask
  task automatic pulse(input logic j, input logic s, input logic f, input logic [2:0] irq);
    @(posedge i_clk);
    i_pc_jump <= j;
    i_pc_step <= s;
    i_alu_flags_we <= f;
    i_sleep_flags_we <= f;
    i_irq_flag_set <= irq;
    @(posedge i_clk);
    {i_pc_jump, i_pc_step, i_alu_flags_we, i_sleep_flags_we} <= 4'h0;
    i_irq_flag_set <= 3'h0;
    @(negedge i_clk);
  endtask
  // reset view: {compare mask, expected}
  function automatic logic [15:0] rv(input logic [7:0] a);
    case (a)
      8'h81, 8'h85, 8'h86, 8'h92: return 16'hffff;
      8'h83: return 16'hf818;
      8'h84: return 16'h0000;
      8'h8b: return 16'hfe00;
      8'h8e: return 16'hff01;
      8'h8f: return 16'hff04;
      8'h94: return 16'hff2a;
      8'h9e: return 16'hff5c;
      default: return 16'hff00;
    endcase
  endfunction
  function automatic logic [7:0] wv(input logic [7:0] a, input logic [7:0] v);
    case (a)
      8'h81, 8'h82, 8'h84, 8'h86, 8'h8b, 8'h92, 8'h93: return v;
      8'h83: return (v & 8'he7) | 8'h18;
      8'h85: return v | 8'h20;
      8'h8a: return v & 8'h1f;
      8'h8c: return v & 8'h4f;
      8'h8d: return v & 8'h10;
      8'h8e: return v & 8'h03;
      8'h8f: return (v & 8'h70) | 8'h04;
      8'h90: return v & 8'h3f;
      8'h94: return (v & 8'hc0) | 8'h2a;
      8'h9e: return 8'h5c;
      8'h9f: return v & 8'hcf;
      default: return 8'h00;
    endcase
  endfunction
  task automatic t_reset_values();
    logic [7:0] q;
    logic [15:0] m;
    for (int a = 'h81; a <= 'h9f; a++) begin
      bus(1'b0, a[8:0], 8'h00, q);
      m = rv(a[7:0]);
      chk({8'h00, q & m[15:8]}, {8'h00, m[7:0]});
    end
  endtask
  task automatic t_write_all(input logic [7:0] v);
    for (int a = 'h81; a <= 'h9f; a++) wr(a[8:0], v);
    for (int a = 'h81; a <= 'h9f; a++) rc(a[8:0], wv(a[7:0], v));
    chk({8'h00, o_port_a_direction}, {8'h00, v | 8'h20});
    chk({10'h000, o_oscillator_tuning}, {10'h000, v[5:0]});
    chk({8'h00, o_timer_and_pullup_options}, {8'h00, v});
    chk({8'h00, o_port_b_direction}, {8'h00, v});
    chk({8'h00, o_peripheral_irq_enable_one}, {8'h00, v & 8'h4f});
    chk({8'h00, o_peripheral_irq_enable_two}, {8'h00, v & 8'h10});
    chk({13'h0000, o_oscillator_freq_select}, {13'h0000, v[6:4]});
    chk({8'h00, o_timer2_period}, {8'h00, v});
    chk({8'h00, o_serial_slave_address}, {8'h00, v});
    chk({14'h0000, o_serial_port_config}, {14'h0000, v[7:6]});
    chk({8'h00, o_conversion_config_one}, {8'h00, v & 8'hcf});
  endtask
  task automatic t_mirror_pc();
    wr(9'h00a, 8'hfb);
    rc(9'h18a, 8'h1b);
    wr(9'h110, 8'h2b);
    rc(9'h090, 8'h2b);
    rc(9'h105, 8'h00);
    wr(9'h082, 8'h34);
    i_jump_target <= 11'h2aa;
    @(negedge i_clk);
    chk({3'h0, o_program_counter}, 16'h1b34);
    pulse(1'b1, 1'b0, 1'b0, 3'h0);
    chk({3'h0, o_program_counter}, 16'h1aaa);
    pulse(1'b0, 1'b1, 1'b0, 3'h0);
    chk({3'h0, o_program_counter}, 16'h1aab);
    wr(9'h08a, 8'h05);
    rc(9'h08a, 8'h05);
    chk({3'h0, o_program_counter}, 16'h1aab);
  endtask
  task automatic t_second_reset();
    wr(9'h084, 8'h5a);
    i_alu_flags <= 3'h5;
    i_sleep_flags <= 2'h2;
    pulse(1'b0, 1'b0, 1'b1, 3'h1);
    rst(1'b0, 1'b1);
    @(negedge i_clk);
    chk({14'h0, o_reset_cause_flags}, 16'h0002);
    chk({8'h00, o_core_flags}, 16'h001d);
    chk({8'h00, o_interrupt_control}, 16'h0001);
    rc(9'h084, 8'h5a);
    wr(9'h084, 8'h40);
    wr(9'h080, 8'h77);
    rc(9'h100, 8'h77);
  endtask
  initial begin
    rst(1'b1, 1'b0);
    t_reset_values();
    t_write_all(8'hff);
    t_write_all(8'h00);
    t_mirror_pc();
    t_second_reset();
    test_done();
  end
endmodule
